// ==== core/mspi_pkg.sv ====
/*
  Shared constants and types for the multi-lane serial pin interface.
  Assumes every user names items as mspi_pkg::name, with no import.
*/
package mspi_pkg;
  localparam int BYTE_W = 8;
  localparam int LANES = 4;
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_W = 6;
  localparam int CNT_W = 4;
  localparam logic [BYTE_W-1:0] TX_IDLE = 8'hFF;
  // pins at rest: select high, pulled-up lanes 2 and 3 high
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 6'h1C;
  localparam logic [LANES-1:0] OE_NONE = 4'h0;
  localparam logic [LANES-1:0] OE_SINGLE = 4'h2;
  localparam logic [LANES-1:0] OE_DUAL = 4'h3;
  localparam logic [LANES-1:0] OE_QUAD = 4'hF;
  localparam logic [CNT_W-1:0] STEP_SINGLE = 4'h1;
  localparam logic [CNT_W-1:0] STEP_DUAL = 4'h2;
  localparam logic [CNT_W-1:0] STEP_QUAD = 4'h4;
  localparam int SO_LANE = 1;
  localparam int SI_LANE = 0;
  localparam int WP_LANE = 2;

  // lane usage, one-hot
  typedef enum logic [2:0] {
    MSPI_SINGLE = 3'h1,
    MSPI_DUAL = 3'h2,
    MSPI_QUAD = 3'h4
  } mspi_mode_t;
endpackage

// ==== core/mspi_buf_if.sv ====
/*
  Valid/ready carrier between the transmit buffer and its two neighbours.
  Assumes one producer on the write side and one consumer on the read side.
*/
`timescale 1ns/1ps
interface mspi_buf_if;
  logic [mspi_pkg::BYTE_W-1:0] wData;
  logic wValid;
  logic wReady;
  logic [mspi_pkg::BYTE_W-1:0] rData;
  logic rValid;
  logic rReady;

  modport store (
    input wData, wValid, rReady,
    output wReady, rData, rValid
  );
  modport user (
    output wData, wValid, rReady,
    input wReady, rData, rValid
  );
endinterface

// ==== core/mspi_buf.sv ====
/*
  Small flip-flop FIFO holding bytes waiting to be shifted out.
  Assumes a single clock; pops are ignored while empty.
*/
`timescale 1ns/1ps
module mspi_buf #(
  parameter int W = mspi_pkg::BYTE_W,
  parameter int D = mspi_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // both sides of the queue
  mspi_buf_if.store bus
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [PW-1:0] LAST = PW'(D - 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  logic [W-1:0] mem_r [D];
  logic [PW-1:0] wPtr_r;
  logic [PW-1:0] rPtr_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic rdy_r;
  logic push;
  logic pop;

  assign push = bus.wValid && rdy_r;
  assign pop = bus.rReady && (cnt_r != '0);
  assign bus.wReady = rdy_r;
  assign bus.rValid = (cnt_r != '0);
  assign bus.rData = mem_r[rPtr_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wPtr_r] <= bus.wData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wPtr_r <= '0;
      rPtr_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
    end else begin
      if (push) begin
        wPtr_r <= (wPtr_r == LAST) ? '0 : wPtr_r + PW'(1);
      end
      if (pop) begin
        rPtr_r <= (rPtr_r == LAST) ? '0 : rPtr_r + PW'(1);
      end
      cnt_r <= cnt_nxt;
      // ready from a flop so the writer never sees a combinational path
      rdy_r <= (cnt_nxt != FULL);
    end
  end

  no_overflow_a: assert property (@(posedge ref_clk) disable iff (rst)
    cnt_r <= FULL) else $error("transmit buffer count above depth");
endmodule

// ==== core/mspi_pins.sv ====
/*
  Pin-level engine of a serial flash: samples the link clock, select and
  four data lanes, shifts bytes in and out in single, dual or quad width.
  Assumes the command logic behind it sets lane mode and direction, and
  that the link clock is far slower than ref_clk (several samples a phase).
*/
`timescale 1ns/1ps
module mspi_pins (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // link pins
  input wire logic sckPin,
  input wire logic csPinN,
  input wire logic [mspi_pkg::LANES-1:0] ioIn,
  output logic [mspi_pkg::LANES-1:0] ioOut,
  output logic [mspi_pkg::LANES-1:0] ioOe,
  // control from command logic
  input wire mspi_pkg::mspi_mode_t laneMode,
  input wire logic dirOut,
  input wire logic quad_enable_bit,
  // received bytes
  output logic [mspi_pkg::BYTE_W-1:0] rxByte,
  output logic rxValid,
  // bytes to send
  input wire logic [mspi_pkg::BYTE_W-1:0] txByte,
  input wire logic txValid,
  output logic txReady,
  // hardware sector lock
  output logic sectorLock
);
  localparam int BW = mspi_pkg::BYTE_W;
  localparam int LW = mspi_pkg::LANES;
  localparam int CW = mspi_pkg::CNT_W;

  logic [mspi_pkg::SYNC_W-1:0] sync1_r;
  logic [mspi_pkg::SYNC_W-1:0] sync2_r;
  logic sckD_r;
  logic sckS;
  logic selected;
  logic [LW-1:0] ioS;
  logic sckRise;
  logic sckFall;
  mspi_pkg::mspi_mode_t effMode;
  logic [CW-1:0] step;
  logic rxOn;
  logic txOn;
  logic [CW-1:0] rxCnt_r;
  logic [CW-1:0] rxSum;
  logic [BW-1:0] rxShift_r;
  logic [BW-1:0] rxShift_nxt;
  logic [BW-1:0] rxByte_r;
  logic rxValid_r;
  logic [CW-1:0] txCnt_r;
  logic [CW-1:0] txSum;
  logic [BW-1:0] txShift_r;
  logic [BW-1:0] txWord;
  logic [LW-1:0] ioOut_r;
  logic [LW-1:0] ioOe_r;
  logic [LW-1:0] ioOe_nxt;
  logic sectorLock_r;
  logic txLoad;
  mspi_buf_if txq ();

  // two-stage synchroniser for everything arriving on pins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // rest at idle pin levels, else release shows a false select and lock
      sync1_r <= mspi_pkg::SYNC_IDLE;
      sync2_r <= mspi_pkg::SYNC_IDLE;
      sckD_r <= 1'b0;
    end else begin
      sync1_r <= {sckPin, csPinN, ioIn};
      sync2_r <= sync1_r;
      sckD_r <= sckS;
    end
  end

  assign sckS = sync2_r[LW+1];
  assign selected = !sync2_r[LW];
  assign ioS = sync2_r[LW-1:0];
  assign sckRise = sckS && !sckD_r && selected;
  assign sckFall = !sckS && sckD_r && selected;

  assign effMode = (laneMode == mspi_pkg::MSPI_QUAD && !quad_enable_bit)
    ? mspi_pkg::MSPI_SINGLE : laneMode;

  always_comb begin
    case (effMode)
      mspi_pkg::MSPI_DUAL: step = mspi_pkg::STEP_DUAL;
      mspi_pkg::MSPI_QUAD: step = mspi_pkg::STEP_QUAD;
      default: step = mspi_pkg::STEP_SINGLE;
    endcase
  end

  // single width is full duplex; wider widths use one direction only
  assign rxOn = (effMode == mspi_pkg::MSPI_SINGLE) || !dirOut;
  assign txOn = (effMode == mspi_pkg::MSPI_SINGLE) || dirOut;
  assign rxSum = rxCnt_r + step;
  assign txSum = txCnt_r + step;

  // lane 0 is the lowest bit of each group
  always_comb begin
    case (effMode)
      mspi_pkg::MSPI_DUAL: rxShift_nxt = {rxShift_r[BW-3:0], ioS[1:0]};
      mspi_pkg::MSPI_QUAD: rxShift_nxt = {rxShift_r[BW-5:0], ioS};
      // single width listens on SI only
      default: rxShift_nxt = {rxShift_r[BW-2:0], ioS[mspi_pkg::SI_LANE]};
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxCnt_r <= '0;
      rxShift_r <= '0;
      rxByte_r <= '0;
      rxValid_r <= 1'b0;
    end else begin
      rxValid_r <= 1'b0;
      if (!selected) begin
        rxCnt_r <= '0;
      end else if (sckRise && rxOn) begin
        rxShift_r <= rxShift_nxt;
        rxCnt_r <= rxSum[CW-1] ? '0 : rxSum;
        if (rxSum[CW-1]) begin
          rxByte_r <= rxShift_nxt;
          rxValid_r <= 1'b1;
        end
      end
    end
  end

  // transmit queue; idle pattern goes out when it runs dry
  assign txq.wData = txByte;
  assign txq.wValid = txValid;
  assign txLoad = sckFall && txOn && (txCnt_r == '0);
  assign txq.rReady = txLoad;
  assign txWord = txq.rValid ? txq.rData : mspi_pkg::TX_IDLE;

  mspi_buf #(
    .W(BW),
    .D(mspi_pkg::BUF_DEPTH)
  ) u_txbuf (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus(txq)
  );

  // launch on falling edge, msb first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txCnt_r <= '0;
      txShift_r <= '0;
      ioOut_r <= '0;
    end else if (!selected) begin
      txCnt_r <= '0;
    end else if (sckFall && txOn) begin
      txCnt_r <= txSum[CW-1] ? '0 : txSum;
      if (txLoad) begin
        txShift_r <= txWord << step;
      end else begin
        txShift_r <= txShift_r << step;
      end
      case (effMode)
        // SI and SO carry bits 0 and 1
        mspi_pkg::MSPI_DUAL:
          ioOut_r <= {2'h0, txLoad ? txWord[BW-1:BW-2] : txShift_r[BW-1:BW-2]};
        mspi_pkg::MSPI_QUAD:
          ioOut_r <= txLoad ? txWord[BW-1:BW-4] : txShift_r[BW-1:BW-4];
        default:
          ioOut_r <= {2'h0, txLoad ? txWord[BW-1] : txShift_r[BW-1], 1'b0};
      endcase
    end
  end

  // drive only in the output phase, release one ref_clk later otherwise
  always_comb begin
    ioOe_nxt = mspi_pkg::OE_NONE;
    if (selected) begin
      case (effMode)
        // dual output owns lanes 1:0, input owns none
        mspi_pkg::MSPI_DUAL: ioOe_nxt = dirOut ? mspi_pkg::OE_DUAL : mspi_pkg::OE_NONE;
        // quad input frees write-protect, output drives it
        mspi_pkg::MSPI_QUAD: ioOe_nxt = dirOut ? mspi_pkg::OE_QUAD : mspi_pkg::OE_NONE;
        default: ioOe_nxt = mspi_pkg::OE_SINGLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ioOe_r <= mspi_pkg::OE_NONE;
    end else begin
      ioOe_r <= ioOe_nxt;
    end
  end

  // low write-protect locks; frozen while the pin carries data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sectorLock_r <= 1'b0;
    end else if (!(selected && effMode == mspi_pkg::MSPI_QUAD)) begin
      sectorLock_r <= !ioS[mspi_pkg::WP_LANE];
    end
  end

  assign ioOut = ioOut_r;
  assign ioOe = ioOe_r;
  assign rxByte = rxByte_r;
  assign rxValid = rxValid_r;
  assign txReady = txq.wReady;
  assign sectorLock = sectorLock_r;

  rise_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
    rxValid_r |-> $past(sckRise)) else $error("byte completed without rising edge");
  fall_launch_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ioOut_r != $past(ioOut_r)) |-> $past(sckFall)) else $error("output moved off falling edge");
  single_si_a: assert property (@(posedge ref_clk) disable iff (rst)
    (selected && effMode == mspi_pkg::MSPI_SINGLE) |=> ioOe_r == mspi_pkg::OE_SINGLE)
    else $error("single width drove a lane other than SO");
  dual_in_a: assert property (@(posedge ref_clk) disable iff (rst)
    (selected && effMode == mspi_pkg::MSPI_DUAL && !dirOut) |=> ioOe_r == mspi_pkg::OE_NONE)
    else $error("dual input still driving");
  dual_out_a: assert property (@(posedge ref_clk) disable iff (rst)
    (selected && effMode == mspi_pkg::MSPI_DUAL && dirOut) |=> ioOe_r == mspi_pkg::OE_DUAL)
    else $error("dual output lanes not driven");
  so_input_a: assert property (@(posedge ref_clk) disable iff (rst)
    (selected && effMode != mspi_pkg::MSPI_SINGLE && !dirOut) |=> !ioOe_r[mspi_pkg::SO_LANE])
    else $error("SO driven during wide input");
  so_output_a: assert property (@(posedge ref_clk) disable iff (rst)
    (selected && effMode != mspi_pkg::MSPI_SINGLE && dirOut) |=> ioOe_r[mspi_pkg::SO_LANE])
    else $error("SO not driven during wide output");
  desel_ignore_a: assert property (@(posedge ref_clk) disable iff (rst)
    !selected |=> (rxCnt_r == '0) && !rxValid_r) else $error("input taken while deselected");
  desel_release_a: assert property (@(posedge ref_clk) disable iff (rst)
    !selected |=> ioOe_r == mspi_pkg::OE_NONE) else $error("lane driven while deselected");
  quad_in_a: assert property (@(posedge ref_clk) disable iff (rst)
    (selected && effMode == mspi_pkg::MSPI_QUAD && !dirOut) |=> !ioOe_r[mspi_pkg::WP_LANE])
    else $error("write-protect driven during quad input");
  quad_out_a: assert property (@(posedge ref_clk) disable iff (rst)
    (selected && effMode == mspi_pkg::MSPI_QUAD && dirOut) |=> ioOe_r == mspi_pkg::OE_QUAD)
    else $error("quad output lanes not driven");
  wp_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    !quad_enable_bit |=> !ioOe_r[mspi_pkg::WP_LANE])
    else $error("write-protect used without enable");
  wp_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(selected && effMode == mspi_pkg::MSPI_QUAD)
    |=> sectorLock_r == !$past(ioS[mspi_pkg::WP_LANE]))
    else $error("sector lock does not follow write-protect");
endmodule

// ==== tb/mspi_host_model.sv ====
/*
  Host-side model: drives link clock (mode 3), select and lanes, samples lanes.
  Assumes the device's lane outputs and enables are fed back to resolve each wire.
*/
`timescale 1ns/1ps
module mspi_host_model (
  // link pins
  output logic sckPin,
  output logic csPinN,
  output logic [3:0] ioIn,
  // device lane drive
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe
);
  logic [3:0] hostOe = 4'h0;
  logic [3:0] hostOut = 4'h0;
  logic [1:0] floatV = 2'b01;
  logic [3:0] idleV;
  logic [3:0] oeSeen = 4'h0;
  int clash = 0;
  initial begin
    sckPin = 1'b1;
    csPinN = 1'b1;
  end
  // wire level; lanes 2 and 3 pulled high
  assign idleV = {2'b11, floatV};
  assign ioIn = (hostOe & hostOut) | (~hostOe & ioOe & ioOut) | (~hostOe & ~ioOe & idleV);
  // counts any fight on a lane
  always @(hostOe or ioOe) if ((hostOe & ioOe) != 4'h0) clash++;
  always @(ioOe) if (!csPinN) oeSeen |= ioOe;
  task automatic frame(input int w, input logic [7:0] wr, input logic [3:0] drv,
                       output logic [7:0] rd);
    logic [7:0] c;
    begin
      rd = 8'h00;
      oeSeen = 4'h0;
      csPinN = 1'b0;
      #40;
      for (int k = 0; k < 8 / w; k++) begin
        sckPin = 1'b0;
        c = wr >> (8 - w * (k + 1));
        hostOut = c[3:0] & ((4'h1 << w) - 4'h1);
        hostOe = drv;
        #32 sckPin = 1'b1;
        rd = (rd << w) | ((w == 1) ? {7'h0, ioIn[1]} : ({4'h0, ioIn} & ((8'h1 << w) - 8'h1)));
        #32;
      end
      // released lines must not keep their last level
      floatV = ~ioIn[1:0];
      hostOe = 4'h0;
      csPinN = 1'b1;
    end
  endtask
  // clocks with select high, SI toggling
  task automatic deadClocks;
    hostOe = 4'h1;
    repeat (8) begin
      hostOut[0] = ~hostOut[0];
      sckPin = 1'b0;
      #32 sckPin = 1'b1;
      #32;
    end
    hostOe = 4'h0;
  endtask
  // low drives the pin, high leaves it to the pull-up
  task automatic setWp(input logic v);
    hostOut[2] = v;
    hostOe[2] = ~v;
  endtask
endmodule

// ==== tb/mspi_pins_tb.sv ====
/*
  Self-checking bench for mspi_pins: table of framed transfers, then deselect,
  buffer and write-protect cases. Assumes the host model in mspi_host_model.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %0h got %0h", n, e, g); fail_count++; end end
module mspi_pins_tb;
  typedef struct {
    mspi_pkg::mspi_mode_t m;
    logic dir;
    logic qe;
    int w;
    logic [7:0] wr;
    logic push;
    logic [7:0] tx;
    logic rx;
    logic [3:0] oe;
  } mspi_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sckPin, csPinN, dirOut, quad_enable_bit, rxValid, txValid, txReady, sectorLock;
  logic [3:0] ioIn, ioOut, ioOe, drv;
  logic [7:0] rxByte, txByte, rxSeen, rd;
  mspi_pkg::mspi_mode_t laneMode;
  int fail_count = 0;
  int tests_run = 0;
  int rxCount = 0;
  int n0;
  logic [7:0] drain [3] = '{8'h11, 8'h22, 8'hFF};
  mspi_row_t rows [6] = '{
    '{mspi_pkg::MSPI_SINGLE, 1'b0, 1'b0, 1, 8'h3C, 1'b1, 8'hA5, 1'b1, 4'h2},
    '{mspi_pkg::MSPI_DUAL, 1'b0, 1'b0, 2, 8'h96, 1'b0, 8'h00, 1'b1, 4'h0},
    '{mspi_pkg::MSPI_DUAL, 1'b1, 1'b0, 2, 8'h00, 1'b1, 8'h5A, 1'b0, 4'h3},
    '{mspi_pkg::MSPI_QUAD, 1'b0, 1'b1, 4, 8'hC3, 1'b0, 8'h00, 1'b1, 4'h0},
    '{mspi_pkg::MSPI_QUAD, 1'b1, 1'b1, 4, 8'h00, 1'b1, 8'h69, 1'b0, 4'hF},
    '{mspi_pkg::MSPI_QUAD, 1'b0, 1'b0, 1, 8'h7E, 1'b1, 8'h81, 1'b1, 4'h2}};
  always #2 ref_clk = ~ref_clk;
  mspi_pins u_mspi_pins (.ref_clk(ref_clk), .rst(rst), .sckPin(sckPin), .csPinN(csPinN),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .laneMode(laneMode), .dirOut(dirOut),
    .quad_enable_bit(quad_enable_bit), .rxByte(rxByte), .rxValid(rxValid), .txByte(txByte),
    .txValid(txValid), .txReady(txReady), .sectorLock(sectorLock));
  mspi_host_model host (.sckPin(sckPin), .csPinN(csPinN), .ioIn(ioIn), .ioOut(ioOut),
    .ioOe(ioOe));
  always @(negedge ref_clk) if (rxValid === 1'b1) begin
    rxSeen <= rxByte;
    rxCount <= rxCount + 1;
  end
  task summarize;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task push(input logic [7:0] b);
    int n;
    begin
      n = 0;
      // idle cycle so back-to-back calls never drop and raise valid at once
      @(negedge ref_clk);
      while (txReady !== 1'b1 && n < 100) begin
        @(negedge ref_clk);
        n++;
      end
      if (n == 100) begin
        fail_count++;
        summarize;
      end
      txByte = b;
      txValid = 1'b1;
      @(negedge ref_clk);
      txValid = 1'b0;
    end
  endtask
  task settle;
    repeat (6) @(negedge ref_clk);
  endtask
  initial begin
    #100000;
    fail_count++;
    summarize;
  end
  initial begin
    txValid = 1'b0;
    txByte = 8'h00;
    laneMode = mspi_pkg::MSPI_SINGLE;
    dirOut = 1'b0;
    quad_enable_bit = 1'b0;
    settle;
    `CHK("ioOe", 4'h0, ioOe)
    `CHK("txReady", 1'b1, txReady)
    rst = 1'b0;
    settle;
    foreach (rows[i]) begin
      laneMode = rows[i].m;
      dirOut = rows[i].dir;
      quad_enable_bit = rows[i].qe;
      if (rows[i].push) push(rows[i].tx);
      n0 = rxCount;
      drv = (rows[i].w == 1) ? 4'h1 : rows[i].dir ? 4'h0 : 4'hF >> (4 - rows[i].w);
      host.frame(rows[i].w, rows[i].wr, drv, rd);
      settle;
      if (rows[i].push) `CHK("read", rows[i].tx, rd)
      `CHK("rxCount", int'(rows[i].rx), rxCount - n0)
      if (rows[i].rx) `CHK("rxByte", rows[i].wr, rxSeen)
      `CHK("oeSeen", rows[i].oe, host.oeSeen)
      `CHK("ioOe", 4'h0, ioOe)
    end
    n0 = rxCount;
    host.deadClocks;
    settle;
    `CHK("deadRx", 0, rxCount - n0)
    `CHK("deadOe", 4'h0, ioOe)
    // fill the buffer while the host stalls, then drain past empty
    laneMode = mspi_pkg::MSPI_SINGLE;
    quad_enable_bit = 1'b0;
    push(8'h11);
    push(8'h22);
    @(negedge ref_clk);
    `CHK("txFull", 1'b0, txReady)
    foreach (drain[i]) begin
      host.frame(1, 8'h00, 4'h1, rd);
      settle;
      `CHK("drain", drain[i], rd)
      `CHK("txRoom", 1'b1, txReady)
    end
    host.setWp(1'b0);
    settle;
    `CHK("lockOn", 1'b1, sectorLock)
    host.setWp(1'b1);
    settle;
    `CHK("lockOff", 1'b0, sectorLock)
    // mid-run reset drops the queued byte and must not glitch lanes or lock
    push(8'h33);
    rst = 1'b1;
    @(negedge ref_clk);
    `CHK("rstRoom", 1'b1, txReady)
    rst = 1'b0;
    repeat (4) begin
      @(negedge ref_clk);
      `CHK("rstOe", 4'h0, ioOe)
      `CHK("rstLock", 1'b0, sectorLock)
    end
    host.frame(1, 8'h00, 4'h1, rd);
    settle;
    `CHK("rstDrop", 8'hFF, rd)
    `CHK("clash", 0, host.clash)
    summarize;
  end
endmodule
